// ### core/disp_pkg.sv
package disp_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_POS = 16;
  localparam int POS_W   = 4;
  localparam int CHAR_W  = 8;
  localparam int SEG_W   = 16;
  localparam int DUTY_W  = 5;
  localparam int ADDR_W  = 8;

  // ----------------------------------------
  // Scan timing, in scan clock cycles
  // ----------------------------------------
  localparam logic [DUTY_W-1:0] SLOT_LAST_NORMAL = 5'h1f;
  localparam logic [DUTY_W-1:0] SLOT_LAST_TEST   = 5'h03;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [DUTY_W-1:0] DUTY_RESET  = 5'h00;
  localparam logic [POS_W-1:0]  COUNT_RESET = 4'h0;
  localparam logic [POS_W-1:0]  PTR_RESET   = 4'hf;
  localparam logic [CHAR_W-1:0] CHAR_RESET  = 8'h20;

  // ----------------------------------------
  // Character codes
  // ----------------------------------------
  localparam logic [6:0] CODE_COMMA     = 7'h2c;
  localparam logic [6:0] CODE_POINT     = 7'h2e;
  localparam logic [6:0] CODE_ALT_COMMA = 7'h6c;
  localparam logic [6:0] CODE_ALT_POINT = 7'h6e;
  localparam logic [SEG_W-1:0] ALT_SEG_2C = 16'h8800;
  localparam logic [SEG_W-1:0] ALT_SEG_2E = 16'h0000;
  localparam logic [SEG_W-1:0] ALT_SEG_6C = 16'h0800;
  localparam logic [SEG_W-1:0] ALT_SEG_6E = 16'h8000;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PTR    = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CHAR   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;
  localparam int CTRL_DUTY_LSB   = 0;
  localparam int CTRL_COUNT_LSB  = 8;
  localparam int CTRL_TEST_BIT   = 16;
  localparam int STATUS_POS_LSB  = 0;
  localparam int STATUS_SLOT_LSB = 8;
  localparam int STATUS_TEST_BIT = 16;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // ----------------------------------------
  // Glyph table, index is code bits 5..0
  // ----------------------------------------
  localparam logic [SEG_W-1:0] GLYPH [64] = '{
    16'h0af7, 16'h03cf, 16'h4a3f, 16'h00f3, 16'h483f, 16'h01f3, 16'h01c3, 16'h02fb,
    16'h03cc, 16'h4833, 16'h007c, 16'h31c0, 16'h00f0, 16'h14cc, 16'h24cc, 16'h00ff,
    16'h03c7, 16'h20ff, 16'h23c7, 16'h03bb, 16'h4803, 16'h00fc, 16'h90c0, 16'ha0cc,
    16'hb400, 16'h5400, 16'h9033, 16'h00e1, 16'h2400, 16'h001e, 16'ha000, 16'h0030,
    16'h0000, 16'h0800, 16'h0880, 16'h4b3c, 16'h4bbb, 16'h95a5, 16'h2d79, 16'h1000,
    16'h3000, 16'h8400, 16'hff00, 16'h4b00, 16'h8000, 16'h0300, 16'h0000, 16'h9000,
    16'h90ff, 16'h000c, 16'h0377, 16'h023f, 16'h038c, 16'h03bb, 16'h03fb, 16'h000f,
    16'h03ff, 16'h03bf, 16'h4800, 16'h8800, 16'h3000, 16'h0330, 16'h8400, 16'h4207
  };

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic              test;
    logic [POS_W-1:0]  count;
    logic [DUTY_W-1:0] duty;
  } settings_type;

  typedef struct packed {
    logic [NUM_POS-1:0] digit;
    logic [SEG_W-1:0]   seg;
    logic               point;
    logic               tail;
  } drive_type;

endpackage

// ### core/char_buffer.sv
`timescale 1ns/10ps
module char_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Registered read port
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("char_buffer depth does not fit address width");
  end

  // Cleared at reset so an unloaded position shows a blank
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= INIT;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= INIT;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // char_buffer

// ### core/segment_display_scan_decoder.sv
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module segment_display_scan_decoder #(
  parameter int NUM_POS     = disp_pkg::NUM_POS,
  parameter bit ALT_VARIANT = 1'b0
) (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [disp_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]                    awprot,
  // AXI4-Lite write data
  input  wire logic                          wvalid,
  output logic                               wready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  // AXI4-Lite write response
  output logic                               bvalid,
  input  wire logic                          bready,
  output logic      [1:0]                    bresp,
  // AXI4-Lite read address
  input  wire logic                          arvalid,
  output logic                               arready,
  input  wire logic [disp_pkg::ADDR_W-1:0]   araddr,
  input  wire logic [2:0]                    arprot,
  // AXI4-Lite read data
  output logic                               rvalid,
  input  wire logic                          rready,
  output logic      [31:0]                   rdata,
  output logic      [1:0]                    rresp,
  // Display drive
  output logic      [NUM_POS-1:0]            digit_drive_outputs,
  output logic      [disp_pkg::SEG_W-1:0]    segment_drive_outputs,
  output logic                               decimal_point_drive,
  output logic                               comma_tail_drive
);

  localparam int PW = disp_pkg::POS_W;
  localparam int DW = disp_pkg::DUTY_W;
  localparam int CW = disp_pkg::CHAR_W;
  localparam int SW = disp_pkg::SEG_W;

  if (NUM_POS != disp_pkg::NUM_POS) begin : g_bad_pos
    $error("Scan logic serves exactly sixteen positions");
  end

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic is_punct(input logic [CW-1:0] code);
    logic [6:0] c;
    c = code[6:0];
    return (c == disp_pkg::CODE_COMMA) || (c == disp_pkg::CODE_POINT) ||
           (c == disp_pkg::CODE_ALT_COMMA) || (c == disp_pkg::CODE_ALT_POINT);
  endfunction

  function automatic logic is_comma(input logic [CW-1:0] code);
    return code[5:0] == disp_pkg::CODE_COMMA[5:0];
  endfunction

  // Base variant looks at bits 5..0 only
  function automatic logic [SW-1:0] decode_seg(input logic [CW-1:0] code);
    logic [SW-1:0] s;
    s = disp_pkg::GLYPH[code[5:0]];
    if (ALT_VARIANT) begin
      case (code[6:0])
        disp_pkg::CODE_COMMA:     s = disp_pkg::ALT_SEG_2C;
        disp_pkg::CODE_POINT:     s = disp_pkg::ALT_SEG_2E;
        disp_pkg::CODE_ALT_COMMA: s = disp_pkg::ALT_SEG_6C;
        disp_pkg::CODE_ALT_POINT: s = disp_pkg::ALT_SEG_6E;
        default:                  s = s;
      endcase
    end
    return s;
  endfunction

  function automatic logic [NUM_POS-1:0] one_hot(input logic [PW-1:0] pos);
    logic [NUM_POS-1:0] v;
    v = '0;
    v[pos] = 1'b1;
    return v;
  endfunction

  // ----------------------------------------
  // Settings and buffer pointer
  // ----------------------------------------
  disp_pkg::settings_type settings_r;
  logic [PW-1:0]          ptr_r;
  logic [NUM_POS-1:0]     point_r;
  logic [NUM_POS-1:0]     tail_r;

  // ----------------------------------------
  // Bus write side
  // ----------------------------------------
  logic                          aw_have_r;
  logic [disp_pkg::ADDR_W-1:0]   awaddr_r;
  logic                          w_have_r;
  logic [31:0]                   wdata_r;
  logic [3:0]                    wstrb_r;
  logic                          bvalid_r;
  logic [1:0]                    bresp_r;
  logic                          do_write;
  logic                          wr_ctrl;
  logic                          wr_ptr;
  logic                          wr_char;
  logic                          wr_mapped;

  assign awready  = !aw_have_r;
  assign wready   = !w_have_r;
  assign bvalid   = bvalid_r;
  assign bresp    = bresp_r;
  assign do_write = aw_have_r && w_have_r && !bvalid_r;
  assign wr_ctrl  = do_write && (awaddr_r == disp_pkg::ADDR_CTRL);
  assign wr_ptr   = do_write && (awaddr_r == disp_pkg::ADDR_PTR) && wstrb_r[0];
  assign wr_char  = do_write && (awaddr_r == disp_pkg::ADDR_CHAR) && wstrb_r[0];
  assign wr_mapped = (awaddr_r == disp_pkg::ADDR_CTRL) || (awaddr_r == disp_pkg::ADDR_PTR) ||
                     (awaddr_r == disp_pkg::ADDR_CHAR) || (awaddr_r == disp_pkg::ADDR_STATUS);

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (awvalid && awready) begin
      aw_have_r <= 1'b1;
      awaddr_r  <= awaddr;
    end else if (do_write) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (wvalid && wready) begin
      w_have_r <= 1'b1;
      wdata_r  <= wdata;
      wstrb_r  <= wstrb;
    end else if (do_write) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= disp_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_mapped ? disp_pkg::RESP_OKAY : disp_pkg::RESP_DECERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Settings registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settings_r.duty  <= disp_pkg::DUTY_RESET;
      settings_r.count <= disp_pkg::COUNT_RESET;
      settings_r.test  <= 1'b0;
    end else if (wr_ctrl) begin
      if (wstrb_r[0]) begin
        settings_r.duty <= wdata_r[disp_pkg::CTRL_DUTY_LSB +: DW];
      end
      if (wstrb_r[1]) begin
        settings_r.count <= wdata_r[disp_pkg::CTRL_COUNT_LSB +: PW];
      end
      // Test lock only leaves through reset
      if (wstrb_r[2] && wdata_r[disp_pkg::CTRL_TEST_BIT]) begin
        settings_r.test <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Character loading
  // ----------------------------------------
  logic [PW-1:0] ptr_inc;
  logic [PW-1:0] store_idx;
  logic [PW-1:0] attach_idx;
  logic          store_en;
  logic          attach_en;

  assign ptr_inc    = ptr_r + 1'b1;
  assign store_idx  = ptr_inc + 1'b1;
  assign attach_idx = ptr_r + 1'b1;
  assign store_en   = wr_char && !is_punct(wdata_r[CW-1:0]);
  assign attach_en  = wr_char && is_punct(wdata_r[CW-1:0]);

  // Pointer value v stores at digit index v+2, so its reset value means digit index 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_r <= disp_pkg::PTR_RESET;
    end else if (wr_ptr) begin
      ptr_r <= wdata_r[PW-1:0];
    end else if (store_en) begin
      ptr_r <= ptr_inc;
    end
  end

  // Point and comma words mark the previous character
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      point_r <= '0;
      tail_r  <= '0;
    end else if (attach_en) begin
      if (is_comma(wdata_r[CW-1:0])) begin
        tail_r[attach_idx] <= 1'b1;
      end else begin
        point_r[attach_idx] <= 1'b1;
      end
    end else if (store_en) begin
      point_r[store_idx] <= 1'b0;
      tail_r[store_idx]  <= 1'b0;
    end
  end

  // ----------------------------------------
  // Refresh scan
  // ----------------------------------------
  logic [DW-1:0] slot_r;
  logic [PW-1:0] pos_r;
  logic [DW-1:0] slot_last;
  logic [PW-1:0] pos_last;
  logic          slot_end;
  logic [PW-1:0] pos_nxt;
  logic          lit;
  logic [CW-1:0] char_code;

  assign slot_last = settings_r.test ? disp_pkg::SLOT_LAST_TEST : disp_pkg::SLOT_LAST_NORMAL;
  assign slot_end  = slot_r >= slot_last;
  assign pos_last  = settings_r.count - 1'b1;
  // Zero wraps to the top index, which gives all sixteen positions
  assign pos_nxt   = !slot_end ? pos_r :
                     (pos_r == pos_last) ? '0 : pos_r + 1'b1;
  // Last cycle of every slot stays dark
  assign lit       = (slot_r < settings_r.duty) && (slot_r < slot_last);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_r <= '0;
    end else if (slot_end) begin
      slot_r <= '0;
    end else begin
      slot_r <= slot_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_r <= '0;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  // Read address runs one cycle ahead so char_code matches pos_r
  char_buffer #(
    .WIDTH (CW),
    .DEPTH (NUM_POS),
    .AW    (PW),
    .INIT  (disp_pkg::CHAR_RESET)
  ) u_buf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (store_en),
    .wr_addr (store_idx),
    .wr_data (wdata_r[CW-1:0]),
    .rd_addr (pos_nxt),
    .rd_data (char_code)
  );

  // ----------------------------------------
  // Output drivers
  // ----------------------------------------
  disp_pkg::drive_type drive_r;
  logic                point_lit;
  logic                tail_lit;

  assign point_lit = point_r[pos_r] || (ALT_VARIANT && char_code[CW-1]);
  assign tail_lit  = tail_r[pos_r];

  // Digit and segments switch together, so a write mid-slot never ghosts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_r <= '0;
    end else if (lit) begin
      drive_r.digit <= one_hot(pos_r);
      drive_r.seg   <= decode_seg(char_code);
      drive_r.point <= point_lit;
      drive_r.tail  <= tail_lit;
    end else begin
      drive_r <= '0;
    end
  end

  assign digit_drive_outputs   = drive_r.digit;
  assign segment_drive_outputs = drive_r.seg;
  assign decimal_point_drive   = drive_r.point;
  assign comma_tail_drive      = drive_r.tail;

  // ----------------------------------------
  // Bus read side
  // ----------------------------------------
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;

  assign arready = !rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  always_comb begin
    rd_word = '0;
    rd_resp = disp_pkg::RESP_OKAY;
    case (araddr)
      disp_pkg::ADDR_CTRL: begin
        rd_word[disp_pkg::CTRL_DUTY_LSB +: DW]  = settings_r.duty;
        rd_word[disp_pkg::CTRL_COUNT_LSB +: PW] = settings_r.count;
        rd_word[disp_pkg::CTRL_TEST_BIT]        = settings_r.test;
      end
      disp_pkg::ADDR_PTR: begin
        rd_word[PW-1:0] = ptr_r;
      end
      disp_pkg::ADDR_CHAR: begin
        rd_word = '0;
      end
      disp_pkg::ADDR_STATUS: begin
        rd_word[disp_pkg::STATUS_POS_LSB +: PW]  = pos_r;
        rd_word[disp_pkg::STATUS_SLOT_LSB +: DW] = slot_r;
        rd_word[disp_pkg::STATUS_TEST_BIT]       = settings_r.test;
      end
      default: begin
        rd_resp = disp_pkg::RESP_DECERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= disp_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= rd_resp;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule // segment_display_scan_decoder

// ### sim/disp_sva.sv
`timescale 1ns/10ps
module disp_sva #(
  parameter int NUM_POS = disp_pkg::NUM_POS
) (
  // Clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Write address handshake
  input wire logic                       awvalid,
  input wire logic                       awready,
  // Display drive
  input wire logic [NUM_POS-1:0]         digit_drive_outputs,
  input wire logic [disp_pkg::SEG_W-1:0] segment_drive_outputs,
  input wire logic                       decimal_point_drive,
  input wire logic                       comma_tail_drive
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [5:0] lit_cnt_r;
  logic       wr_seen_r;
  logic       lit;
  assign lit = |digit_drive_outputs;

  // Consecutive lit cycles before this one
  always_ff @(posedge aclk) begin
    if (!aresetn) lit_cnt_r <= 6'h00;
    else if (lit) lit_cnt_r <= lit_cnt_r + 6'h01;
    else lit_cnt_r <= 6'h00;
  end

  // Duty can only leave zero through a register write
  always_ff @(posedge aclk) begin
    if (!aresetn) wr_seen_r <= 1'b0;
    else if (awvalid && awready) wr_seen_r <= 1'b1;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_RST_DIGIT: assert property (@(posedge aclk) !aresetn |=> !lit)
    else $error("digit drive active after reset");
  AST_RST_SEG: assert property (@(posedge aclk) !aresetn |=>
    segment_drive_outputs == '0 && !decimal_point_drive && !comma_tail_drive)
    else $error("segment drive active after reset");
  AST_ONE_DIGIT: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot0(digit_drive_outputs)) else $error("more than one digit on");
  AST_SEG_GATED: assert property (@(posedge aclk) disable iff (!aresetn)
    !lit |-> segment_drive_outputs == '0) else $error("segments lit with no digit");
  AST_MARK_GATED: assert property (@(posedge aclk) disable iff (!aresetn)
    !lit |-> !decimal_point_drive && !comma_tail_drive)
    else $error("point or tail lit with no digit");
  AST_MAX_ON: assert property (@(posedge aclk) disable iff (!aresetn)
    lit |-> lit_cnt_r < 6'd31) else $error("digit on longer than 31 cycles");
  AST_OFF_GAP: assert property (@(posedge aclk) disable iff (!aresetn)
    lit && $changed(digit_drive_outputs) |-> $past(digit_drive_outputs) == '0)
    else $error("no off cycle between digits");
  AST_DARK_AT_START: assert property (@(posedge aclk) disable iff (!aresetn)
    !wr_seen_r |-> !lit) else $error("display lit before any setting write");
endmodule // disp_sva

bind segment_display_scan_decoder disp_sva #(.NUM_POS(NUM_POS)) sva_u (
  .aclk, .aresetn, .awvalid, .awready, .digit_drive_outputs,
  .segment_drive_outputs, .decimal_point_drive, .comma_tail_drive);

// ### sim/disp_panel.sv
`timescale 1ns/10ps
module disp_panel (
  // Clock and clear
  input  wire logic        aclk,
  input  wire logic        clr,
  // Drive lines
  input  wire logic [15:0] digit,
  input  wire logic [15:0] seg,
  input  wire logic        point,
  input  wire logic        tail,
  // Observations
  output logic [15:0][15:0] seen_seg,
  output logic [15:0]       seen_pt,
  output logic [15:0]       seen_tl,
  output logic [5:0]        run_len,
  output logic [15:0]       runs,
  output logic [3:0]        max_pos,
  output logic [7:0]        jumps
);
  logic [5:0] cur_r;
  logic [3:0] pos_r;
  logic       lit_r;
  // ----------------------------------------
  // Passive glass: records what lights up
  // ----------------------------------------
  always @(posedge aclk) begin : obs
    int p;
    p = 0;
    for (int i = 0; i < 16; i++) if (digit[i]) p = i;
    if (clr) begin
      runs <= 16'h0000;
      max_pos <= 4'h0;
      jumps <= 8'h00;
      cur_r <= 6'h00;
      lit_r <= 1'b0;
    end else if (digit != 16'h0000) begin
      cur_r <= cur_r + 6'h01;
      seen_seg[p] <= seg;
      seen_pt[p] <= point;
      seen_tl[p] <= tail;
      if (!lit_r) begin
        runs <= runs + 16'h0001;
        pos_r <= 4'(p);
        if (4'(p) > max_pos) max_pos <= 4'(p);
        // Only the next position or a wrap to the first is legal
        if (runs != 16'h0000 && 4'(p) != pos_r + 4'h1 && p != 0) jumps <= jumps + 8'h01;
      end
      lit_r <= 1'b1;
    end else begin
      if (lit_r) run_len <= cur_r;
      cur_r <= 6'h00;
      lit_r <= 1'b0;
    end
  end
endmodule // disp_panel

// ### sim/test_segment_display_scan_decoder.sv
`timescale 1ns/10ps
module test_segment_display_scan_decoder;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pt, tl, clr;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_r;
  logic [15:0] dig, seg, seen_pt, seen_tl, runs;
  logic [15:0][15:0] seen_seg;
  logic [5:0]  run_len;
  logic [3:0]  max_pos;
  logic [7:0]  jumps;
  logic [7:0]  code [16];
  logic [15:0] dig_a, seg_a, seen_pt_a;
  logic        pt_a, tl_a;
  int n_fail, checked;

  segment_display_scan_decoder dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .digit_drive_outputs(dig),
    .segment_drive_outputs(seg), .decimal_point_drive(pt), .comma_tail_drive(tl));
  disp_panel panel_u (.aclk(aclk), .clr(clr), .digit(dig), .seg(seg), .point(pt),
    .tail(tl), .seen_seg(seen_seg), .seen_pt(seen_pt), .seen_tl(seen_tl),
    .run_len(run_len), .runs(runs), .max_pos(max_pos), .jumps(jumps));
  // Alternate build on the same bus; its bus answers match dut_u, so they go unread
  segment_display_scan_decoder #(.ALT_VARIANT(1'b1)) alt_u (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(), .wdata(wdata), .wstrb(wstrb), .bvalid(), .bready(bready), .bresp(),
    .arvalid(arvalid), .arready(), .araddr(araddr), .arprot(3'h0), .rvalid(),
    .rready(rready), .rdata(), .rresp(), .digit_drive_outputs(dig_a),
    .segment_drive_outputs(seg_a), .decimal_point_drive(pt_a), .comma_tail_drive(tl_a));
  disp_panel alt_panel_u (.aclk(aclk), .clr(clr), .digit(dig_a), .seg(seg_a), .point(pt_a),
    .tail(tl_a), .seen_seg(), .seen_pt(seen_pt_a), .seen_tl(), .run_len(), .runs(),
    .max_pos(), .jumps());

  always #5 aclk = ~aclk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Handshakes are judged at the falling edge, taken at the next rising one
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      ha = awvalid && awready; hw = wvalid && wready; hb = bvalid;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
      n++;
    end while (!hb && n < 50);
    if (!hb) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    logic ha, hr;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      ha = arvalid && arready; hr = rvalid; rd_v = rdata; rd_r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
      n++;
    end while (!hr && n < 50);
    if (!hr) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic rescan(input int n);
    @(posedge aclk); clr <= 1'b1;
    @(posedge aclk); clr <= 1'b0;
    cyc(n);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    aclk = 0; aresetn = 0; clr = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
    rready = 0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf;
    n_fail = 0; checked = 0;
    cyc(10);
    aresetn <= 1'b1;
    cyc(2);
    chk("digits", 32'h0, 32'(dig));
    chk("segments", 32'h0, {14'h0, seg, pt, tl});
    axi_rd(disp_pkg::ADDR_CTRL);
    chk("duty", 32'h0, 32'(rd_v[4:0]));
    chk("count", 32'h0, 32'(rd_v[11:8]));
    axi_rd(disp_pkg::ADDR_PTR);
    chk("pointer", 32'hf, 32'(rd_v[3:0]));
    axi_rd(8'h40);
    chk("unmapped", 32'(disp_pkg::RESP_DECERR), 32'(rd_r));
    // Fill every position, one code with bit 7 set
    for (int i = 0; i < 16; i++) code[i] = (i < 10) ? 8'h30 + 8'(i) : 8'h37 + 8'(i);
    code[5] = 8'hb5;
    axi_wr(disp_pkg::ADDR_PTR, 32'he);
    for (int i = 0; i < 16; i++) axi_wr(disp_pkg::ADDR_CHAR, 32'(code[i]));
    axi_wr(disp_pkg::ADDR_PTR, 32'h2);
    axi_wr(disp_pkg::ADDR_CHAR, 32'h2e);
    axi_wr(disp_pkg::ADDR_CHAR, 32'h2c);
    axi_wr(disp_pkg::ADDR_CTRL, 32'h5);
    rescan(1100);
    for (int i = 0; i < 16; i++) chk("glyph", 32'(disp_pkg::GLYPH[code[i][5:0]]), 32'(seen_seg[i]));
    chk("zero glyph", 32'h90ff, 32'(seen_seg[0]));
    chk("points", 32'h8, 32'(seen_pt));
    chk("alt points", 32'h28, 32'(seen_pt_a));
    chk("tails", 32'h8, 32'(seen_tl));
    chk("on time", 32'd5, 32'(run_len));
    chk("last pos", 32'hf, 32'(max_pos));
    chk("order", 32'h0, 32'(jumps));
    chk("wrapped", 32'h1, 32'(runs > 16'd16));
    axi_wr(disp_pkg::ADDR_CTRL, 32'h1f);
    rescan(1100);
    chk("max on time", 32'd31, 32'(run_len));
    axi_wr(disp_pkg::ADDR_CTRL, 32'h51f);
    cyc(600);
    rescan(400);
    chk("limited pos", 32'h4, 32'(max_pos));
    chk("limited order", 32'h0, 32'(jumps));
    axi_wr(disp_pkg::ADDR_CTRL, 32'h0);
    cyc(40);
    rescan(200);
    chk("dark runs", 32'h0, 32'(runs));
    // Test lock goes last: only a reset leaves it
    axi_wr(disp_pkg::ADDR_CTRL, 32'h1001f);
    rescan(200);
    chk("test on time", 32'd3, 32'(run_len));
    axi_rd(disp_pkg::ADDR_STATUS);
    chk("test lock", 32'h1, 32'(rd_v[16]));
    aresetn <= 1'b0;
    cyc(3);
    aresetn <= 1'b1;
    cyc(2);
    chk("digits again", 32'h0, 32'(dig));
    chk("segments again", 32'h0, {14'h0, seg, pt, tl});
    axi_rd(disp_pkg::ADDR_CTRL);
    chk("ctrl again", 32'h0, rd_v);
    axi_rd(disp_pkg::ADDR_PTR);
    chk("pointer again", 32'hf, rd_v);
    tally_and_finish();
  end
endmodule // test_segment_display_scan_decoder
